// ---- verilog/sag_swell_logger.sv ----
// sag and swell detector with event log entry output
`timescale 1ns/1ps
// Functional notes
// R1 - check every cycle rms against phase limits
// R2 - below lower limit means sag
// R3 - above upper limit means swell
// R4 - crossing starts event, log if longer
// R5 - one minimum cycle count for all
// R6 - enhanced resolution selects low input gain
// R7 - ignore phase b on two-element wiring
// R8 - log per-phase v, i extremes and averages
// R9 - entry holds seconds time, cycles, status
// R10 - up to 600 cycles gives one entry
// R11 - longer gives start and end entries
// R12 - eighteen status codes from form, kind, phase
// R13 - saturating duration counter, packed status encoding
// R14 - averages are sum divided by cycle count
module sag_swell_logger
    import sag_swell_pkg::*;
#(
    parameter int unsigned VW = VAL_W,
    parameter int unsigned DW = DUR_W,
    parameter int unsigned TW = TIME_W
) (
    input  wire logic                    clk,
    input  wire logic                    rst_n,
    input  wire logic                    cycle_stb,
    input  wire logic [N_PH-1:0][VW-1:0] v_rms,
    input  wire logic [N_PH-1:0][VW-1:0] i_rms,
    input  wire logic [N_PH-1:0][VW-1:0] pf_val,
    input  wire logic [N_PH-1:0][VW-1:0] sag_limit,
    input  wire logic [N_PH-1:0][VW-1:0] swell_limit,
    input  wire logic [DW-1:0]           min_cycles,
    input  wire logic                    enh_res_en,
    input  wire logic                    two_element,
    input  wire logic [TW-1:0]           sec_time,
    output logic                         gain_low,
    output logic                         log_valid,
    output logic [ST_W-1:0]              log_status,
    output logic [TW-1:0]                log_time,
    output logic [DW-1:0]                log_dur,
    output logic [N_PH-1:0][VW-1:0]      log_v_max,
    output logic [N_PH-1:0][VW-1:0]      log_v_min,
    output logic [N_PH-1:0][VW-1:0]      log_v_avg,
    output logic [N_PH-1:0][VW-1:0]      log_i_max,
    output logic [N_PH-1:0][VW-1:0]      log_i_min,
    output logic [N_PH-1:0][VW-1:0]      log_i_avg,
    output logic [N_PH-1:0][VW-1:0]      log_pf_avg
);
    localparam logic [DW-1:0] SEG = DW'(SEG_CYC);  // segment length

    logic [N_PH-1:0]           is_sag;      // phase below its lower limit
    logic [N_PH-1:0]           is_swell;    // phase above its upper limit
    logic                      hit;         // some phase out of limits
    logic [1:0]                hit_ph;      // first such phase
    logic                      hit_kind;    // sag or swell of that phase
    logic                      still;       // tracked excursion persists
    ev_state_e                 state_q, state_d;
    logic [DW-1:0]             dur_q, dur_d;       // cycles so far
    logic [1:0]                ph_q, ph_d;         // tracked phase
    logic                      kind_q, kind_d;     // tracked kind
    logic [TW-1:0]             t0_q, t0_d;         // start second
    logic                      lstart_q, lstart_d; // long start logged
    logic                      gain_q, gain_d;     // low gain select
    logic                      clr_c, acc_c;       // statistics commands
    logic                      emit_c;             // write an entry now
    logic [1:0]                form_c;             // entry form
    logic [N_PH-1:0][VW-1:0]   s_vmax, s_vmin, s_vavg;
    logic [N_PH-1:0][VW-1:0]   s_imax, s_imin, s_iavg, s_pavg;
    logic                      lv_q, lv_d;
    logic [ST_W-1:0]           lst_q, lst_d;
    logic [TW-1:0]             lt_q, lt_d;
    logic [DW-1:0]             ld_q, ld_d;
    logic [N_PH-1:0][VW-1:0]   lvx_q, lvx_d, lvn_q, lvn_d, lva_q, lva_d;
    logic [N_PH-1:0][VW-1:0]   lix_q, lix_d, lin_q, lin_d, lia_q, lia_d;
    logic [N_PH-1:0][VW-1:0]   lpa_q, lpa_d;

    ////////////////////////////////////////////////////////////////////////
    // per-phase statistics units
    phase_stat_if #(.VW(VW)) sif [N_PH] ();

    for (genvar g = 0; g < N_PH; g++) begin : g_ph
        // R8 every phase tracked
        assign sif[g].clr = clr_c;
        assign sif[g].acc = acc_c;
        assign sif[g].v   = v_rms[g];
        assign sif[g].i   = i_rms[g];
        assign sif[g].pf  = pf_val[g];
        assign s_vmax[g]  = sif[g].v_max;
        assign s_vmin[g]  = sif[g].v_min;
        assign s_vavg[g]  = sif[g].v_avg;
        assign s_imax[g]  = sif[g].i_max;
        assign s_imin[g]  = sif[g].i_min;
        assign s_iavg[g]  = sif[g].i_avg;
        assign s_pavg[g]  = sif[g].pf_avg;
        phase_stat #(.VW(VW), .CW(CNT_W)) u_stat (
            .clk   (clk),
            .rst_n (rst_n),
            .s     (sif[g])
        );
    end

    ////////////////////////////////////////////////////////////////////////
    // limit comparison and phase selection
    always_comb begin
        hit      = 1'b0;
        hit_ph   = 2'h0;
        hit_kind = KIND_SAG;
        for (int p = 0; p < N_PH; p++) begin
            // R1 R2 lower limit check
            is_sag[p]   = v_rms[p] < sag_limit[p];
            // R3 upper limit check
            is_swell[p] = v_rms[p] > swell_limit[p];
            // R7 phase b masked
            if (two_element && p == PH_B) begin
                is_sag[p]   = 1'b0;
                is_swell[p] = 1'b0;
            end
        end
        // lowest phase wins, sag before swell
        for (int p = N_PH - 1; p >= 0; p--) begin
            if (is_sag[p] || is_swell[p]) begin
                hit      = 1'b1;
                hit_ph   = 2'(p);
                hit_kind = is_sag[p] ? KIND_SAG : KIND_SWELL;
            end
        end
        still = (kind_q == KIND_SAG) ? is_sag[ph_q] : is_swell[ph_q];
    end

    ////////////////////////////////////////////////////////////////////////
    // event tracker next state
    always_comb begin
        state_d  = state_q;
        dur_d    = dur_q;
        ph_d     = ph_q;
        kind_d   = kind_q;
        t0_d     = t0_q;
        lstart_d = lstart_q;
        clr_c    = 1'b0;
        acc_c    = 1'b0;
        emit_c   = 1'b0;
        form_c   = FORM_SHORT;
        // R6 gain follows enhanced mode
        gain_d   = enh_res_en;
        if (cycle_stb) begin
            unique case (state_q)
                ST_IDLE: begin
                    // R4 crossing opens an event
                    if (hit) begin
                        state_d  = ST_RUN;
                        ph_d     = hit_ph;
                        kind_d   = hit_kind;
                        dur_d    = DW'(1);
                        t0_d     = sec_time;
                        lstart_d = 1'b0;
                        clr_c    = 1'b1;
                    end
                end
                ST_RUN, ST_LONG: begin
                    if (still) begin
                        // R13 counter saturates
                        if (dur_q != '1) dur_d = dur_q + DW'(1);
                        // R11 statistics cover first segment
                        acc_c = dur_q < SEG;
                        if (dur_d > SEG) state_d = ST_LONG;
                        // R11 R5 long start entry
                        if (dur_d > SEG && dur_d > min_cycles &&
                            !lstart_q) begin
                            emit_c   = 1'b1;
                            form_c   = FORM_LSTART;
                            lstart_d = 1'b1;
                        end
                    end else begin
                        state_d = ST_IDLE;
                        if (state_q == ST_RUN) begin
                            // R10 R5 short entry if long enough
                            emit_c = dur_q > min_cycles;
                            form_c = FORM_SHORT;
                        end else begin
                            // R11 end entry after a start entry
                            emit_c = lstart_q;
                            form_c = FORM_LEND;
                        end
                    end
                end
                default: state_d = ST_IDLE;
            endcase
        end
    end

    // register the event tracker
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q  <= ST_IDLE;
            dur_q    <= '0;
            ph_q     <= 2'h0;
            kind_q   <= KIND_SAG;
            t0_q     <= '0;
            lstart_q <= 1'b0;
            gain_q   <= 1'b0;
        end else begin
            state_q  <= state_d;
            dur_q    <= dur_d;
            ph_q     <= ph_d;
            kind_q   <= kind_d;
            t0_q     <= t0_d;
            lstart_q <= lstart_d;
            gain_q   <= gain_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // log entry next values
    always_comb begin
        lv_d  = 1'b0;
        lst_d = lst_q;
        lt_d  = lt_q;
        ld_d  = ld_q;
        lvx_d = lvx_q;
        lvn_d = lvn_q;
        lva_d = lva_q;
        lix_d = lix_q;
        lin_d = lin_q;
        lia_d = lia_q;
        lpa_d = lpa_q;
        if (emit_c) begin
            lv_d  = 1'b1;
            // R12 form, kind and phase packed
            lst_d = status_code(form_c, kind_q, ph_q);
            // R9 start second, end second for end entries
            lt_d  = (form_c == FORM_LEND) ? sec_time : t0_q;
            ld_d  = (form_c == FORM_LSTART) ? dur_d : dur_q;
            // R8 statistics snapshot
            lvx_d = s_vmax;
            lvn_d = s_vmin;
            lva_d = s_vavg;
            lix_d = s_imax;
            lin_d = s_imin;
            lia_d = s_iavg;
            lpa_d = s_pavg;
        end
    end

    // register the log entry
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lv_q  <= 1'b0;
            lst_q <= '0;
            lt_q  <= '0;
            ld_q  <= '0;
            lvx_q <= '0;
            lvn_q <= '0;
            lva_q <= '0;
            lix_q <= '0;
            lin_q <= '0;
            lia_q <= '0;
            lpa_q <= '0;
        end else begin
            lv_q  <= lv_d;
            lst_q <= lst_d;
            lt_q  <= lt_d;
            ld_q  <= ld_d;
            lvx_q <= lvx_d;
            lvn_q <= lvn_d;
            lva_q <= lva_d;
            lix_q <= lix_d;
            lin_q <= lin_d;
            lia_q <= lia_d;
            lpa_q <= lpa_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs straight from flip-flops
    assign gain_low   = gain_q;
    assign log_valid  = lv_q;
    assign log_status = lst_q;
    assign log_time   = lt_q;
    assign log_dur    = ld_q;
    assign log_v_max  = lvx_q;
    assign log_v_min  = lvn_q;
    assign log_v_avg  = lva_q;
    assign log_i_max  = lix_q;
    assign log_i_min  = lin_q;
    assign log_i_avg  = lia_q;
    assign log_pf_avg = lpa_q;
endmodule // sag_swell_logger

// ---- verilog/sag_swell_pkg.sv ----
// constants, status encoding and state type for the sag and swell logger
package sag_swell_pkg;
    localparam int unsigned VAL_W   = 16;   // rms and pf sample width
    localparam int unsigned DUR_W   = 16;   // cycle duration counter width
    localparam int unsigned TIME_W  = 32;   // seconds time stamp width
    localparam int unsigned N_PH    = 3;    // phases a, b, c
    localparam int unsigned CNT_W   = 10;   // holds one full segment count
    localparam int unsigned SEG_CYC = 600;  // longest single-entry event
    localparam int unsigned PH_B    = 1;    // index of phase b
    localparam int unsigned ST_W    = 5;    // status code width
    // status code forms
    localparam logic [1:0] FORM_SHORT  = 2'h0;
    localparam logic [1:0] FORM_LSTART = 2'h1;
    localparam logic [1:0] FORM_LEND   = 2'h2;
    // excursion kinds
    localparam logic KIND_SAG   = 1'h0;
    localparam logic KIND_SWELL = 1'h1;
    // event tracker states, gray along idle, run, long
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_RUN  = 2'b01,
        ST_LONG = 2'b11
    } ev_state_e;
    // status code packing: form, kind, phase
    function automatic logic [ST_W-1:0] status_code(
        input logic [1:0] form,
        input logic       kind,
        input logic [1:0] ph
    );
        return {form, kind, ph};
    endfunction
endpackage

// ---- verilog/phase_stat_if.sv ----
// carrier between the event tracker and one phase statistics unit
`timescale 1ns/1ps
interface phase_stat_if #(
    parameter int unsigned VW = 16
);
    logic          clr;     // restart with the current sample
    logic          acc;     // fold the current sample in
    logic [VW-1:0] v;       // cycle rms voltage
    logic [VW-1:0] i;       // cycle rms current
    logic [VW-1:0] pf;      // cycle power factor
    logic [VW-1:0] v_max;
    logic [VW-1:0] v_min;
    logic [VW-1:0] v_avg;
    logic [VW-1:0] i_max;
    logic [VW-1:0] i_min;
    logic [VW-1:0] i_avg;
    logic [VW-1:0] pf_avg;
    modport ctrl (output clr, acc, v, i, pf,
                  input v_max, v_min, v_avg, i_max, i_min, i_avg, pf_avg);
    modport unit (input clr, acc, v, i, pf,
                  output v_max, v_min, v_avg, i_max, i_min, i_avg, pf_avg);
endinterface // phase_stat_if

// ---- verilog/phase_stat.sv ----
// per-phase min, max and average tracker over one event segment
`timescale 1ns/1ps
module phase_stat
    import sag_swell_pkg::*;
#(
    parameter int unsigned VW = VAL_W,
    parameter int unsigned CW = CNT_W
) (
    input  wire logic clk,
    input  wire logic rst_n,
    phase_stat_if.unit s
);
    localparam int unsigned SW = VW + CW;  // sum width, no overflow
    logic [VW-1:0] vmax_q, vmax_d, vmin_q, vmin_d;
    logic [VW-1:0] imax_q, imax_d, imin_q, imin_d;
    logic [SW-1:0] vsum_q, vsum_d, isum_q, isum_d, psum_q, psum_d;
    logic [CW-1:0] cnt_q, cnt_d;           // cycles folded in
    logic [VW-1:0] vavg_q, vavg_d, iavg_q, iavg_d, pavg_q, pavg_d;

    ////////////////////////////////////////////////////////////////////////
    // next values: restart, accumulate, and running averages
    always_comb begin
        vmax_d = vmax_q;
        vmin_d = vmin_q;
        imax_d = imax_q;
        imin_d = imin_q;
        vsum_d = vsum_q;
        isum_d = isum_q;
        psum_d = psum_q;
        cnt_d  = cnt_q;
        if (s.clr) begin
            // first cycle of an event seeds every statistic
            vmax_d = s.v;
            vmin_d = s.v;
            imax_d = s.i;
            imin_d = s.i;
            vsum_d = SW'(s.v);
            isum_d = SW'(s.i);
            psum_d = SW'(s.pf);
            cnt_d  = CW'(1);
        end else if (s.acc) begin
            // later cycles widen extremes and grow sums
            if (s.v > vmax_q) vmax_d = s.v;
            if (s.v < vmin_q) vmin_d = s.v;
            if (s.i > imax_q) imax_d = s.i;
            if (s.i < imin_q) imin_d = s.i;
            vsum_d = vsum_q + SW'(s.v);
            isum_d = isum_q + SW'(s.i);
            psum_d = psum_q + SW'(s.pf);
            cnt_d  = cnt_q + CW'(1);
        end
        // R14 sum over count
        if (cnt_q == '0) begin
            vavg_d = '0;
            iavg_d = '0;
            pavg_d = '0;
        end else begin
            vavg_d = VW'(vsum_q / SW'(cnt_q));
            iavg_d = VW'(isum_q / SW'(cnt_q));
            pavg_d = VW'(psum_q / SW'(cnt_q));
        end
    end

    // register the statistics
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            vmax_q <= '0;
            vmin_q <= '0;
            imax_q <= '0;
            imin_q <= '0;
            vsum_q <= '0;
            isum_q <= '0;
            psum_q <= '0;
            cnt_q  <= '0;
            vavg_q <= '0;
            iavg_q <= '0;
            pavg_q <= '0;
        end else begin
            vmax_q <= vmax_d;
            vmin_q <= vmin_d;
            imax_q <= imax_d;
            imin_q <= imin_d;
            vsum_q <= vsum_d;
            isum_q <= isum_d;
            psum_q <= psum_d;
            cnt_q  <= cnt_d;
            vavg_q <= vavg_d;
            iavg_q <= iavg_d;
            pavg_q <= pavg_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // results back over the carrier
    assign s.v_max  = vmax_q;
    assign s.v_min  = vmin_q;
    assign s.v_avg  = vavg_q;
    assign s.i_max  = imax_q;
    assign s.i_min  = imin_q;
    assign s.i_avg  = iavg_q;
    assign s.pf_avg = pavg_q;
endmodule // phase_stat

// ---- verification/sag_swell_logger_chk.sv ----
// concurrent checks on the sag and swell logger ports
`timescale 1ns/1ps
module sag_swell_logger_chk
    import sag_swell_pkg::*;
#(
    parameter int unsigned VW = VAL_W,
    parameter int unsigned DW = DUR_W
) (
    input wire logic                    clk,
    input wire logic                    rst_n,
    input wire logic                    cycle_stb,
    input wire logic                    enh_res_en,
    input wire logic                    two_element,
    input wire logic [DW-1:0]           min_cycles,
    input wire logic                    gain_low,
    input wire logic                    log_valid,
    input wire logic [ST_W-1:0]         log_status,
    input wire logic [DW-1:0]           log_dur,
    input wire logic [N_PH-1:0][VW-1:0] log_v_max,
    input wire logic [N_PH-1:0][VW-1:0] log_v_min,
    input wire logic [N_PH-1:0][VW-1:0] log_v_avg
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////////////////////////////////
    // entry timing and hold
    a_entry_after_stb: assert property (log_valid |-> $past(cycle_stb))
        else $error("entry without a deciding strobe");
    a_entry_one_pulse: assert property (log_valid |=> !log_valid)
        else $error("entry valid longer than one cycle");
    a_fields_held: assert property (!log_valid |-> $stable(log_status)
        && $stable(log_dur)) else $error("entry fields moved between entries");
    ////////////////////////////////////////////////////////////////////
    // entry contents
    a_dur_above_min: assert property (log_valid &&
        log_status[4:3] != FORM_LEND |-> log_dur > $past(min_cycles))
        else $error("entry not longer than minimum");
    a_short_len_cap: assert property (log_valid &&
        log_status[4:3] == FORM_SHORT |-> log_dur <= SEG_CYC)
        else $error("short entry over segment length");
    a_long_start_len: assert property (log_valid &&
        log_status[4:3] == FORM_LSTART |-> log_dur == SEG_CYC + 1
        || log_dur == $past(min_cycles) + 1)
        else $error("long start entry duration off");
    a_codes_legal: assert property (log_valid |-> log_status[4:3] != 2'h3
        && log_status[1:0] != 2'h3) else $error("illegal status code");
    a_phase_b_skip: assert property (log_valid && two_element
        |-> log_status[1:0] != 2'(PH_B)) else $error("phase b logged");
    a_stats_order: assert property (log_valid |-> log_v_min[0] <=
        log_v_avg[0] && log_v_avg[0] <= log_v_max[0])
        else $error("phase a min avg max out of order");
    a_gain_follow: assert property ($changed(enh_res_en) |=>
        gain_low == $past(enh_res_en)) else $error("gain select late");
    ////////////////////////////////////////////////////////////////////
    // main scenarios seen
    c_short: cover property (log_valid && log_status[4:3] == FORM_SHORT);
    c_lstart: cover property (log_valid && log_status[4:3] == FORM_LSTART);
    c_lend: cover property (log_valid && log_status[4:3] == FORM_LEND);
    c_gain: cover property ($rose(gain_low));
endmodule // sag_swell_logger_chk

bind sag_swell_logger sag_swell_logger_chk #(.VW(VW), .DW(DW)) chk_u (
    .clk, .rst_n, .cycle_stb, .enh_res_en, .two_element, .min_cycles,
    .gain_low, .log_valid, .log_status, .log_dur, .log_v_max,
    .log_v_min, .log_v_avg);

// ---- verification/rms_front_end.sv ----
// behavioural per-cycle rms front end that feeds the logger
`timescale 1ns/1ps
module rms_front_end
    import sag_swell_pkg::*;
(
    input  wire logic                       clk,
    input  wire logic                       rst_n,
    input  wire logic                       en,
    input  wire logic [N_PH-1:0][VAL_W-1:0] v_in,
    input  wire logic [N_PH-1:0][VAL_W-1:0] i_in,
    input  wire logic [N_PH-1:0][VAL_W-1:0] pf_in,
    output logic                            cycle_stb,
    output logic [N_PH-1:0][VAL_W-1:0]      v_rms,
    output logic [N_PH-1:0][VAL_W-1:0]      i_rms,
    output logic [N_PH-1:0][VAL_W-1:0]      pf_val
);
    logic [1:0] cnt_q; // strobe every fourth clock
    // values change at the falling edge; stale values are inverted so
    // nothing can pass on a leftover sample
    always @(negedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= 2'h0;
            cycle_stb <= 1'b0;
            v_rms <= '0;
            i_rms <= '0;
            pf_val <= '0;
        end else begin
            cnt_q <= cnt_q + 2'h1;
            cycle_stb <= en && cnt_q == 2'h3;
            if (en && cnt_q == 2'h3) begin
                v_rms <= v_in;
                i_rms <= i_in;
                pf_val <= pf_in;
            end else if (cycle_stb) begin
                v_rms <= ~v_rms;
                i_rms <= ~i_rms;
                pf_val <= ~pf_val;
            end
        end
    end
endmodule // rms_front_end

// ---- verification/sag_swell_logger_tb_top.sv ----
// self-checking bench for the sag and swell logger
`timescale 1ns/1ps
module sag_swell_logger_tb_top
    import sag_swell_pkg::*;
;
    logic                       clk, rst_n, en, cycle_stb;
    logic                       enh_res_en, two_element, gain_low, log_valid;
    logic [N_PH-1:0][VAL_W-1:0] v_rms, i_rms, pf_val, v_set, i_set, pf_set;
    logic [N_PH-1:0][VAL_W-1:0] sag_limit, swell_limit, log_v_max, log_v_min;
    logic [N_PH-1:0][VAL_W-1:0] log_v_avg, log_i_max, log_i_min, log_i_avg;
    logic [N_PH-1:0][VAL_W-1:0] log_pf_avg;
    logic [DUR_W-1:0]           min_cycles, log_dur;
    logic [TIME_W-1:0]          sec_time, log_time, t0, seed;
    logic [ST_W-1:0]            log_status;
    logic [31:0]                e_st[2], e_dur[2], e_tm[2];
    int                         num_errors, comparisons, ent;
    int vmx[3], vmn[3], vsm[3], imx[3], imn[3], ism[3], psm[3];

    sag_swell_logger dut_u (.clk, .rst_n, .cycle_stb, .v_rms, .i_rms,
        .pf_val, .sag_limit, .swell_limit, .min_cycles, .enh_res_en,
        .two_element, .sec_time, .gain_low, .log_valid, .log_status,
        .log_time, .log_dur, .log_v_max, .log_v_min, .log_v_avg,
        .log_i_max, .log_i_min, .log_i_avg, .log_pf_avg);
    rms_front_end fe_u (.clk, .rst_n, .en, .v_in(v_set), .i_in(i_set),
        .pf_in(pf_set), .cycle_stb, .v_rms, .i_rms, .pf_val);

    ////////////////////////////////////////////////////////////////////
    // helpers
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic chk(input string nm, input logic [31:0] seen, exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic report_and_stop();
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // one excursion of n strobes on phase ph, then one strobe in band
    task automatic ev(input int ph, input logic kd, input int n);
        int c;
        c = (n > SEG_CYC) ? SEG_CYC : n;
        ent = 0;
        for (int p = 0; p < 3; p++) begin
            vmx[p] = 0; vmn[p] = 'hffff; vsm[p] = 0; psm[p] = 0;
            imx[p] = 0; imn[p] = 'hffff; ism[p] = 0;
        end
        @(posedge clk);
        #1;
        for (int k = 0; k <= n; k++) begin
            for (int p = 0; p < 3; p++) begin
                v_set[p] = 16'(1100 + rnd() % 800);
                if (k < n && p == ph)
                    v_set[p] = kd ? 16'(2001 + rnd() % 500)
                                  : 16'(999 - rnd() % 500);
                i_set[p] = 16'(rnd());
                pf_set[p] = 16'(rnd());
                if (k < c) begin
                    if (v_set[p] > vmx[p]) vmx[p] = v_set[p];
                    if (v_set[p] < vmn[p]) vmn[p] = v_set[p];
                    if (i_set[p] > imx[p]) imx[p] = i_set[p];
                    if (i_set[p] < imn[p]) imn[p] = i_set[p];
                    vsm[p] += v_set[p];
                    ism[p] += i_set[p];
                    psm[p] += pf_set[p];
                end
            end
            @(posedge clk iff cycle_stb === 1'b1);
            #1;
            if (k == 0) t0 = sec_time;
        end
        repeat (3) @(posedge clk);
        #1;
        if (n <= min_cycles || (two_element && ph == PH_B))
            chk("entries", ent, 0);
        else if (n <= SEG_CYC) begin
            chk("entries", ent, 1);
            chk("status", e_st[0], {FORM_SHORT, kd, 2'(ph)});
            chk("duration", e_dur[0], n);
            chk("start time", e_tm[0], t0);
        end else begin
            chk("entries", ent, 2);
            chk("status", e_st[0], {FORM_LSTART, kd, 2'(ph)});
            chk("start dur", e_dur[0], SEG_CYC + 1);
            chk("start time", e_tm[0], t0);
            chk("end status", e_st[1], {FORM_LEND, kd, 2'(ph)});
            chk("end dur", e_dur[1], n);
            chk("end time", e_tm[1], t0 + n);
        end
        if (ent > 0)
            for (int p = 0; p < 3; p++) begin
                chk("v max", log_v_max[p], vmx[p]);
                chk("v min", log_v_min[p], vmn[p]);
                chk("v avg", log_v_avg[p], vsm[p] / c);
                chk("i max", log_i_max[p], imx[p]);
                chk("i min", log_i_min[p], imn[p]);
                chk("i avg", log_i_avg[p], ism[p] / c);
                chk("pf avg", log_pf_avg[p], psm[p] / c);
            end
    endtask

    ////////////////////////////////////////////////////////////////////
    // clock, seconds count and entry capture
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    always @(negedge clk) begin
        if (!rst_n) sec_time <= 32'h0000_0100;
        else if (cycle_stb) sec_time <= sec_time + 32'h1;
        if (log_valid === 1'b1) begin
            if (ent < 2) begin
                e_st[ent] = log_status;
                e_dur[ent] = log_dur;
                e_tm[ent] = log_time;
            end
            ent++;
        end
    end
    // watchdog well past the expected run length
    initial begin
        #300000;
        num_errors++;
        report_and_stop();
    end

    ////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        rst_n = 1'b0; en = 1'b0; enh_res_en = 1'b0; two_element = 1'b0;
        min_cycles = 16'h0002; seed = 32'h5844;
        v_set = '0; i_set = '0; pf_set = '0; ent = 0;
        num_errors = 0; comparisons = 0;
        for (int p = 0; p < 3; p++) begin
            sag_limit[p] = 16'h03e8;
            swell_limit[p] = 16'h07d0;
        end
        repeat (6) @(posedge clk);
        @(negedge clk);
        rst_n = 1'b1;
        en = 1'b1;
        ev(0, KIND_SAG, 2); // at the minimum: dropped
        ev(0, KIND_SAG, 3);
        for (int p = 0; p < 3; p++)
            for (int k = 0; k < 2; k++) ev(p, k[0], 3 + rnd() % 20);
        @(negedge clk);
        min_cycles = 16'(5 + rnd() % 10);
        ev(2, KIND_SWELL, min_cycles);
        ev(2, KIND_SWELL, min_cycles + 1);
        ev(1, KIND_SAG, SEG_CYC); // longest single entry
        for (int p = 0; p < 3; p++)
            for (int k = 0; k < 2; k++) ev(p, k[0], 601 + rnd() % 4);
        @(negedge clk);
        two_element = 1'b1;
        ev(1, KIND_SAG, 6);
        ev(1, KIND_SWELL, 6);
        ev(2, KIND_SAG, 6);
        @(negedge clk);
        two_element = 1'b0;
        enh_res_en = 1'b1;
        #1 chk("gain low", gain_low, 0);
        @(negedge clk);
        chk("gain low", gain_low, 1);
        enh_res_en = 1'b0;
        @(negedge clk);
        chk("gain low", gain_low, 0);
        report_and_stop();
    end
endmodule // sag_swell_logger_tb_top
